// >>> hdl/rtci_pkg.sv
package rtci_pkg;

    // ------------------------------------------------------------
    // Register map (printed offsets not all multiples of four: indices)
    // ------------------------------------------------------------
    localparam logic [3:0] FLAGS_IDX = 4'h0;       // Event flags register index
    localparam logic [3:0] CTRL_IDX = 4'h6;        // Interrupt control register index
    localparam logic [3:0] STAT_IDX = 4'h1;        // Status register index
    localparam logic [7:0] FLAGS_ADDR = {2'h0, FLAGS_IDX, 2'h0};
    localparam logic [7:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
    localparam logic [7:0] STAT_ADDR = {2'h0, STAT_IDX, 2'h0};

    // ------------------------------------------------------------
    // Flags register fields
    // ------------------------------------------------------------
    localparam int FL_WDOG = 7;                    // wdog_flag
    localparam int FL_ALARM = 6;                   // alarm_flag
    localparam int FL_PWRFAIL = 5;                 // pwrfail_flag
    localparam int FL_OSCFAIL = 4;                 // osc_fail_flag
    localparam int FL_BKFAIL = 3;                  // Backup fail flag
    localparam int FL_CAL = 2;                     // Calibration test output
    localparam int FL_WREN = 1;                    // Write enable for flags
    localparam int FL_RDLATCH = 0;                 // Read latch bit
    localparam logic [7:0] FLAGS_RESET = 8'h00;

    // ------------------------------------------------------------
    // Interrupt control register fields
    // ------------------------------------------------------------
    localparam int CT_WDOG_EN = 7;                 // wdog_irq_en
    localparam int CT_ALARM_EN = 6;                // alarm_irq_en
    localparam int CT_PWRFAIL_EN = 5;              // pwrfail_irq_en
    localparam int CT_SQW_EN = 4;                  // sqwave_en
    localparam int CT_HIGH = 3;                    // Active high, push-pull
    localparam int CT_PULSE = 2;                   // Pulse mode
    localparam int CT_FSEL_HI = 1;                 // freq_sel_hi
    localparam int CT_FSEL_LO = 0;                 // freq_sel_lo
    localparam logic [7:0] CTRL_RESET = 8'h08;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ = 100_000_000;
    localparam longint PULSE_MS = 200;             // Pulse width in ms
    localparam longint PULSE_CYC = CLK_HZ / 1000 * PULSE_MS;
    localparam longint SETTLE_US = 1000;           // powerup_settle_time, us
    localparam longint SETTLE_CYC = (CLK_HZ / 1_000_000) * SETTLE_US;
    localparam longint F_1HZ = 1;
    localparam longint F_512HZ = 512;
    localparam longint F_4096HZ = 4096;
    localparam longint F_32KHZ = 32768;
    // Half periods in cycles, rounded down
    localparam longint HALF_1HZ = CLK_HZ / (2 * F_1HZ);
    localparam longint HALF_512HZ = CLK_HZ / (2 * F_512HZ);
    localparam longint HALF_4096HZ = CLK_HZ / (2 * F_4096HZ);
    localparam longint HALF_32KHZ = CLK_HZ / (2 * F_32KHZ);

    // Output source select
    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_CAL,
        SRC_SQW,
        SRC_EVENT
    } rtci_src_t;

endpackage

// >>> hdl/rtci_irq.sv
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
module rtci_irq #(
    parameter longint PULSE_CYCLES = rtci_pkg::PULSE_CYC,
    parameter longint SETTLE_CYCLES = rtci_pkg::SETTLE_CYC,
    parameter longint HALF_1HZ_CYCLES = rtci_pkg::HALF_1HZ,
    parameter longint HALF_512_CYCLES = rtci_pkg::HALF_512HZ
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Event sources and supply state (asynchronous pins)
    input wire logic WDOG_TIMEOUT,
    input wire logic ALARM_MATCH,
    input wire logic PWRFAIL_DET,
    input wire logic OSC_FAIL,
    input wire logic BACKUP_FAIL,
    input wire logic ON_BACKUP,
    // Nonvolatile copy of square-wave settings
    input wire logic [2:0] NV_SQW_IN,
    output logic [2:0] NV_SQW_OUT,
    // Interrupt pin, two signals
    output logic INT_O,
    output logic INT_OE
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 6;
    logic [NSYNC-1:0] raw_in;       // Asynchronous pins
    logic [NSYNC-1:0] sync1_q;      // First stage, read only by second
    logic [NSYNC-1:0] sync2_q;      // Safe stage
    logic [NSYNC-1:0] sync3_q;      // Previous safe value for edges
    assign raw_in = {ON_BACKUP, BACKUP_FAIL, OSC_FAIL, PWRFAIL_DET, ALARM_MATCH, WDOG_TIMEOUT};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            // Two flops plus edge history for each pin
            always_ff @(posedge CORE_CLK) begin
                if (RST) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                    sync3_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= raw_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                end
            end
        end
    endgenerate

    // Edge detects read only the safe stage and its history
    logic wdog_evt;     // Rising edge of watchdog timeout
    logic alarm_evt;    // Rising edge of alarm match
    logic pwrfail_evt;  // Rising edge of power-fail detect
    logic on_backup;    // Running from backup supply
    assign wdog_evt = sync2_q[0] & ~sync3_q[0];
    assign alarm_evt = sync2_q[1] & ~sync3_q[1];
    assign pwrfail_evt = sync2_q[2] & ~sync3_q[2];
    assign on_backup = sync2_q[5];

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic acc;          // Access phase
    logic hit_flags;
    logic hit_ctrl;
    logic hit_stat;
    logic mapped;
    logic wr_flags;
    logic wr_ctrl;
    logic rd_flags;     // Flags read completing this cycle
    assign acc = PSEL & PENABLE;
    assign hit_flags = PADDR == rtci_pkg::FLAGS_ADDR;
    assign hit_ctrl = PADDR == rtci_pkg::CTRL_ADDR;
    assign hit_stat = PADDR == rtci_pkg::STAT_ADDR;
    // Any other address answers with an error and no effect
    assign mapped = hit_flags | hit_ctrl | hit_stat;
    assign wr_flags = acc & PWRITE & hit_flags;
    assign wr_ctrl = acc & PWRITE & hit_ctrl;
    assign rd_flags = acc & ~PWRITE & hit_flags;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [2:0] evflag_q;   // wdog_flag, alarm_flag, pwrfail_flag
    logic [2:0] evflag_d;
    logic osc_fail_flag_q;
    logic bk_fail_q;
    logic cal_q;            // Calibration test bit
    logic wren_q;           // Flags write enable
    logic [7:0] ctrl_q;     // Interrupt control
    logic nv_loaded_q;      // Nonvolatile settings restored
    logic [2:0] ev_in;
    // Sources in flag order: watchdog, alarm, power fail
    assign ev_in = {wdog_evt, alarm_evt, pwrfail_evt};

    // Set wins over the read clear
    assign evflag_d = (rd_flags ? 3'h0 : evflag_q) | ev_in;

    // Flags and their write-enabled control bits
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            evflag_q <= rtci_pkg::FLAGS_RESET[7:5];
            cal_q <= 1'b0;
            wren_q <= 1'b0;
        end else begin
            evflag_q <= evflag_d;
            if (wr_flags) begin
                wren_q <= PWDATA[rtci_pkg::FL_WREN];
                if (wren_q) begin
                    cal_q <= PWDATA[rtci_pkg::FL_CAL];
                end
            end
        end
    end

    // Oscillator and backup fail flags keep their own behaviour: set by pins
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            osc_fail_flag_q <= 1'b0;
            bk_fail_q <= 1'b0;
        end else begin
            if (sync2_q[3]) begin
                osc_fail_flag_q <= 1'b1;
            end else if (wr_flags && wren_q && !PWDATA[rtci_pkg::FL_OSCFAIL]) begin
                osc_fail_flag_q <= 1'b0;
            end
            if (sync2_q[4]) begin
                bk_fail_q <= 1'b1;
            end else if (wr_flags && wren_q && !PWDATA[rtci_pkg::FL_BKFAIL]) begin
                bk_fail_q <= 1'b0;
            end
        end
    end

    // Control register; square-wave bits restored from storage after reset
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ctrl_q <= rtci_pkg::CTRL_RESET;
            nv_loaded_q <= 1'b0;
        end else if (!nv_loaded_q) begin
            nv_loaded_q <= 1'b1;
            ctrl_q[rtci_pkg::CT_SQW_EN] <= NV_SQW_IN[2];
            ctrl_q[rtci_pkg::CT_FSEL_HI:rtci_pkg::CT_FSEL_LO] <= NV_SQW_IN[1:0];
        end else if (wr_ctrl) begin
            ctrl_q <= PWDATA[7:0];
        end
    end

    // ------------------------------------------------------------
    // Settling counter after power-up
    // ------------------------------------------------------------
    localparam int SW = 32;
    logic [SW-1:0] settle_q;
    logic settled_q;
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            settle_q <= '0;
            settled_q <= 1'b0;
        end else if (!settled_q) begin
            settle_q <= settle_q + 1'b1;
            settled_q <= settle_q >= SW'(SETTLE_CYCLES - 1);
        end
    end

    // ------------------------------------------------------------
    // Event interrupt request and pulse timer
    // ------------------------------------------------------------
    // Enable bits line up with the three event flags
    logic [2:0] en_bits;
    logic ev_req;       // Enabled flag present
    logic ev_new;       // New enabled event this cycle
    logic pulse_mode;
    logic [SW-1:0] pulse_q;
    logic pulse_act_q;
    assign en_bits = ctrl_q[rtci_pkg::CT_WDOG_EN:rtci_pkg::CT_PWRFAIL_EN];
    assign ev_req = |(evflag_q & en_bits);
    assign ev_new = |(ev_in & en_bits) & ~on_backup & settled_q;
    assign pulse_mode = ctrl_q[rtci_pkg::CT_PULSE];

    // Pulse runs for its fixed count, restarted by each new event, unless a flags read cuts it short
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            pulse_q <= '0;
            pulse_act_q <= 1'b0;
        end else if (ev_new) begin
            pulse_q <= SW'(PULSE_CYCLES - 1);
            pulse_act_q <= 1'b1;
        end else if (rd_flags) begin
            pulse_act_q <= 1'b0;
        end else if (pulse_act_q) begin
            pulse_q <= pulse_q - 1'b1;
            pulse_act_q <= pulse_q != '0;
        end
    end

    logic ev_active;    // Event asserts pin
    // Level mode follows enabled flags until read clears them; a running pulse
    // is dropped as soon as the supply switches to backup
    assign ev_active = (pulse_mode ? pulse_act_q : ev_req) & settled_q & ~on_backup;

    // ------------------------------------------------------------
    // Square wave and calibration dividers
    // ------------------------------------------------------------
    logic [SW-1:0] sqw_half;
    logic [SW-1:0] sqw_cnt_q;
    logic sqw_q;
    logic [SW-1:0] cal_cnt_q;
    logic cal_wave_q;
    logic [1:0] fsel;
    assign fsel = ctrl_q[rtci_pkg::CT_FSEL_HI:rtci_pkg::CT_FSEL_LO];
    assign sqw_half = (fsel == 2'h0) ? SW'(HALF_1HZ_CYCLES) :
                      (fsel == 2'h1) ? SW'(HALF_512_CYCLES) :
                      (fsel == 2'h2) ? SW'(rtci_pkg::HALF_4096HZ) :
                      SW'(rtci_pkg::HALF_32KHZ);

    // Selected square wave
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            sqw_cnt_q <= '0;
            sqw_q <= 1'b0;
        end else if (sqw_cnt_q >= sqw_half - 1'b1) begin
            sqw_cnt_q <= '0;
            sqw_q <= ~sqw_q;
        end else begin
            sqw_cnt_q <= sqw_cnt_q + 1'b1;
        end
    end

    // Fixed 512 Hz test wave
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            cal_cnt_q <= '0;
            cal_wave_q <= 1'b0;
        end else if (cal_cnt_q >= SW'(HALF_512_CYCLES - 1)) begin
            cal_cnt_q <= '0;
            cal_wave_q <= ~cal_wave_q;
        end else begin
            cal_cnt_q <= cal_cnt_q + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Output resolution and pin driver
    // ------------------------------------------------------------
    rtci_pkg::rtci_src_t src;
    logic act;          // Logical active level of the pin
    logic high_pol;
    logic drv_en;
    logic drv_val;
    assign src = cal_q ? rtci_pkg::SRC_CAL :
                 ctrl_q[rtci_pkg::CT_SQW_EN] ? rtci_pkg::SRC_SQW :
                 ev_active ? rtci_pkg::SRC_EVENT : rtci_pkg::SRC_NONE;
    assign high_pol = ctrl_q[rtci_pkg::CT_HIGH];

    // Waves are suppressed on backup power
    always_comb begin
        case (src)
            rtci_pkg::SRC_CAL: act = cal_wave_q & ~on_backup;
            rtci_pkg::SRC_SQW: act = sqw_q & ~on_backup;
            rtci_pkg::SRC_EVENT: act = 1'b1;
            default: act = 1'b0;
        endcase
    end

    // Push-pull drives both levels for a wave, only high for an event; open drain only pulls low
    assign drv_en = (src == rtci_pkg::SRC_NONE) ? 1'b0 :
                    high_pol ? ~on_backup : act;
    assign drv_val = high_pol ? act : 1'b0;

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            INT_O <= 1'b0;
            INT_OE <= 1'b0;
        end else begin
            INT_O <= drv_val;
            INT_OE <= drv_en;
        end
    end

    // ------------------------------------------------------------
    // APB answer: no wait states, registered read data
    // ------------------------------------------------------------
    // Read views of the three registers
    logic [7:0] flags_rd;
    logic [7:0] stat_rd;
    logic [31:0] rd_mux;
    assign flags_rd = {evflag_q, osc_fail_flag_q, bk_fail_q, cal_q, wren_q, 1'b0};
    assign stat_rd = {4'h0, on_backup, settled_q, pulse_act_q, ev_active};
    assign rd_mux = hit_flags ? {24'h0, flags_rd} :
                    hit_ctrl ? {24'h0, ctrl_q} :
                    hit_stat ? {24'h0, stat_rd} : 32'h0;

    // Ready in the setup cycle so the access phase completes at once
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            PRDATA <= 32'h0;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            NV_SQW_OUT <= 3'h0;
        end else begin
            PREADY <= PSEL & ~PENABLE;
            PSLVERR <= PSEL & ~PENABLE & ~mapped;
            PRDATA <= (PSEL & ~PENABLE & ~PWRITE) ? rd_mux : 32'h0;
            NV_SQW_OUT <= {ctrl_q[rtci_pkg::CT_SQW_EN], fsel};
        end
    end

endmodule // rtci_irq

// >>> testbench/rtci_irq_asserts.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Pin and bus checks, tracking control bits from APB writes
// ------------------------------------------------------------
module rtci_irq_asserts #(
    parameter longint PULSE_CYCLES = 50,
    parameter longint SETTLE_CYCLES = 20
) (
    // Clock, reset and APB
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Sources and pin
    input wire logic ALARM_MATCH,
    input wire logic ON_BACKUP,
    input wire logic INT_O,
    input wire logic INT_OE
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    wire commit = PSEL && PENABLE && PREADY;                    // Transfer completes
    wire wr_c = commit && PWRITE && (PADDR == rtci_pkg::CTRL_ADDR);
    wire wr_f = commit && PWRITE && (PADDR == rtci_pkg::FLAGS_ADDR);
    wire rd_f = commit && !PWRITE && (PADDR == rtci_pkg::FLAGS_ADDR);
    logic [7:0] ctrl_q;                                         // Shadow of control reg
    logic wren_q;                                               // Shadow of write enable
    logic cal_q;                                                // Shadow of calibration bit
    longint settle_q;                                           // Cycles since reset
    longint run_q;                                              // Active cycles in a row
    wire act = INT_OE && (INT_O == ctrl_q[rtci_pkg::CT_HIGH]);  // Pin at active level
    wire quiet = !ctrl_q[rtci_pkg::CT_SQW_EN] && !cal_q;        // No waveform override
    wire ready = settle_q >= SETTLE_CYCLES + 8;                 // Past settling
    // Shadow registers follow committed writes
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ctrl_q <= rtci_pkg::CTRL_RESET;
            wren_q <= 1'b0;
            cal_q <= 1'b0;
            settle_q <= 0;
            run_q <= 0;
        end else begin
            if (wr_c) ctrl_q <= PWDATA[7:0];
            if (wr_f) wren_q <= PWDATA[rtci_pkg::FL_WREN];
            if (wr_f && wren_q) cal_q <= PWDATA[rtci_pkg::FL_CAL];
            if (!ready) settle_q <= settle_q + 1;
            run_q <= act ? run_q + 1 : 0;
        end
    end
    sequence s_alarm;
        $rose(ALARM_MATCH) ##0 (ctrl_q[rtci_pkg::CT_ALARM_EN] && quiet && !ON_BACKUP && ready);
    endsequence
    property p_err; PSLVERR |-> PREADY; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_idle; !PREADY |-> PRDATA == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside access");
    property p_settle; (!ready && quiet) |-> !act; endproperty
    a_settle: assert property (p_settle) else $error("pin active while settling");
    property p_backup; ON_BACKUP [*4] |-> !INT_OE; endproperty
    a_backup: assert property (p_backup) else $error("pin driven on backup");
    property p_odrain; (!ctrl_q[rtci_pkg::CT_HIGH]) [*3] |-> !(INT_OE && INT_O); endproperty
    a_odrain: assert property (p_odrain) else $error("open drain drove high");
    property p_noen; (quiet && ctrl_q[7:5] == 3'h0) [*3] |-> !act; endproperty
    a_noen: assert property (p_noen) else $error("active with no enable");
    property p_alarm; s_alarm |-> ##[3:6] act; endproperty
    a_alarm: assert property (p_alarm) else $error("alarm not on pin");
    property p_lvl; rd_f && quiet && !ctrl_q[rtci_pkg::CT_PULSE] |-> ##2 !act; endproperty
    a_lvl: assert property (p_lvl) else $error("level not cleared");
    property p_cut; rd_f && quiet && ctrl_q[rtci_pkg::CT_PULSE] |-> ##2 !act; endproperty
    a_cut: assert property (p_cut) else $error("pulse not cut");
    property p_pw; ctrl_q[rtci_pkg::CT_PULSE] && quiet |-> run_q <= PULSE_CYCLES; endproperty
    a_pw: assert property (p_pw) else $error("pulse too long");
endmodule // rtci_irq_asserts

// >>> testbench/rtci_host_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Host side of the pin: pull-up, active detect, pulse width
// ------------------------------------------------------------
module rtci_host_model (
    // Pin and mode
    input wire logic clk,
    input wire logic int_o,
    input wire logic int_oe,
    input wire logic high,
    input wire logic armed,
    // Observations
    output logic pin,
    output logic act,
    output int width
);
    logic last_q;  // Last pin level, for a floating push-pull line
    int run_q;     // Length of the current active run
    // Open drain idles at the pull-up; floating push-pull changes each cycle
    assign pin = int_oe ? int_o : (high ? ~last_q : 1'b1);
    // Pin activity is disregarded until settled
    assign act = armed && (high ? (int_oe && int_o) : !pin);
    // Width of the last finished active run
    always_ff @(posedge clk) begin
        last_q <= pin;
        run_q <= act ? run_q + 1 : 0;
        if (!act && run_q != 0) width <= run_q;
    end
endmodule // rtci_host_model

// >>> testbench/tb_rtci_irq.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Bench: APB register tasks and pin tests
// ------------------------------------------------------------
module tb_rtci_irq;
    localparam longint PW = 50;   // Shortened pulse
    localparam longint ST = 20;   // Shortened settling
    localparam longint H1 = 40;   // Shortened 1 Hz half period
    localparam longint H5 = 10;   // Shortened 512 Hz half period
    localparam longint tbl [4] = '{H1, H5, rtci_pkg::HALF_4096HZ, rtci_pkg::HALF_32KHZ};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, on_backup = 1'b0, armed = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, int_o, int_oe, pin, act;
    logic [2:0] ev = 3'h0;   // {wdog, alarm, pwrfail}
    logic [2:0] nvout;
    int width, d, n_errors = 0, n_compared = 0;
    always #5 clk = ~clk;
    rtci_irq #(.PULSE_CYCLES(PW), .SETTLE_CYCLES(ST), .HALF_1HZ_CYCLES(H1),
        .HALF_512_CYCLES(H5)) dut_u (.CORE_CLK(clk), .RST(rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .WDOG_TIMEOUT(ev[2]),
        .ALARM_MATCH(ev[1]), .PWRFAIL_DET(ev[0]), .OSC_FAIL(1'b0), .BACKUP_FAIL(1'b0),
        .ON_BACKUP(on_backup), .NV_SQW_IN(3'h0), .NV_SQW_OUT(nvout), .INT_O(int_o),
        .INT_OE(int_oe));
    rtci_host_model host_u (.clk(clk), .int_o(int_o), .int_oe(int_oe),
        .high(1'b0), .armed(armed), .pin(pin), .act(), .width());
    rtci_host_model hhi_u (.clk(clk), .int_o(int_o), .int_oe(int_oe), .high(1'b1),
        .armed(armed), .pin(), .act(act), .width(width));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // Compare and count
    task check(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %0t got %h want %h", $time, s, e);
        end
    endtask
    // One APB transfer, held until pready
    task apb(input logic w, input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, v};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Pulse one event source, then let it reach the pin
    task fire(input int i);
        ev[i] <= 1'b1;
        repeat (3) @(posedge clk);
        ev[i] <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    // Cycles between two toggles of the active level
    task half(output int n);
        logic v;
        v = act;
        while (act === v) @(posedge clk);
        v = act;
        n = 0;
        while (act === v) begin
            @(posedge clk);
            n++;
        end
    endtask
    // Counts and verdict
    task complete_run;
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Watchdog on the whole run
    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        complete_run;
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        apb(0, rtci_pkg::CTRL_ADDR, 8'h00);
        check(rd, 32'h08);
        apb(0, rtci_pkg::FLAGS_ADDR, 8'h00);
        check(rd, 32'h0);
        apb(0, 8'h3c, 8'h00);
        check(er, 1'b1);
        check(rd, 32'h0);
        repeat (ST + 10) @(posedge clk);
        armed <= 1'b1;
        $display("registers done");
        // Each source in level mode, active low
        for (int i = 0; i < 3; i++) begin
            apb(1, rtci_pkg::CTRL_ADDR, 8'(8'h20 << i));
            fire(i);
            check({int_oe, pin}, 2'b10);
            apb(0, rtci_pkg::FLAGS_ADDR, 8'h00);
            check(rd, 32'h20 << i);
            repeat (2) @(posedge clk);
            check(int_oe, 1'b0);
        end
        apb(1, rtci_pkg::CTRL_ADDR, 8'h00);
        for (int i = 0; i < 3; i++) fire(i);
        check(int_oe, 1'b0);
        apb(0, rtci_pkg::FLAGS_ADDR, 8'h00);
        check(rd, 32'he0);
        apb(0, rtci_pkg::FLAGS_ADDR, 8'h00);
        check(rd, 32'h0);
        $display("level done");
        // Pulse mode, active high; full width with no flags read, then a pulse cut short by a flags read
        apb(1, rtci_pkg::CTRL_ADDR, 8'h4c);
        fire(1);
        check({int_oe, int_o}, 2'b11);
        repeat (PW + 5) @(posedge clk);
        check(width, 32'(PW));
        apb(0, rtci_pkg::FLAGS_ADDR, 8'h00);
        fire(1);
        apb(0, rtci_pkg::FLAGS_ADDR, 8'h00);
        repeat (3) @(posedge clk);
        check({act, width < PW}, 2'b01);
        $display("pulse done");
        // Backup supply blocks the pin, flag still set
        on_backup <= 1'b1;
        apb(1, rtci_pkg::CTRL_ADDR, 8'h40);
        fire(1);
        check(int_oe, 1'b0);
        apb(0, rtci_pkg::FLAGS_ADDR, 8'h00);
        check(rd, 32'h40);
        on_backup <= 1'b0;
        $display("backup done");
        // Square wave overrides a pending alarm, every frequency
        apb(1, rtci_pkg::CTRL_ADDR, 8'h58);
        fire(1);
        for (int f = 0; f < 4; f++) begin
            apb(1, rtci_pkg::CTRL_ADDR, 8'h58 | 8'(f));
            half(d);
            check(d, 32'(tbl[f]));
            check(nvout, {1'b1, 2'(f)});
        end
        $display("square wave done");
        // Calibration wins over the square wave
        apb(1, rtci_pkg::FLAGS_ADDR, 8'h02);
        apb(1, rtci_pkg::FLAGS_ADDR, 8'h06);
        half(d);
        check(d, 32'(H5));
        apb(1, rtci_pkg::FLAGS_ADDR, 8'h02);
        apb(1, rtci_pkg::FLAGS_ADDR, 8'h00);
        apb(0, rtci_pkg::FLAGS_ADDR, 8'h00);
        apb(1, rtci_pkg::CTRL_ADDR, 8'h08);
        repeat (3) @(posedge clk);
        check(int_oe, 1'b0);
        $display("calibration done");
        complete_run;
    end
endmodule // tb_rtci_irq
bind rtci_irq rtci_irq_asserts #(.PULSE_CYCLES(PULSE_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES))
    chk_u (.CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .ALARM_MATCH(ALARM_MATCH), .ON_BACKUP(ON_BACKUP), .INT_O(INT_O), .INT_OE(INT_OE));
